// File: src/plls_map.svh
// Register offsets, field positions, reset values and counts of the clock synthesizer.
// Included by the package and by the synthesizer top; the output counter does not include it.
`ifndef PLLS_MAP_SVH
`define PLLS_MAP_SVH

// ****************************************
// Reconfiguration map
// ****************************************
`define PLLS_ADDR_RATIO0    5'h00
`define PLLS_ADDR_PHASE0    5'h06
`define PLLS_ADDR_DUTY0     5'h0c
`define PLLS_ADDR_FBMULT    5'h12
`define PLLS_ADDR_PRESCALE  5'h13
`define PLLS_ADDR_FBPHASE   5'h14
`define PLLS_ADDR_MODE      5'h15
`define PLLS_NUM_CFG        22
`define PLLS_NUM_OUT        6
`define PLLS_MODE_COMP_BIT  0
`define PLLS_MODE_BW_HI     2
`define PLLS_MODE_BW_LO     1

// ****************************************
// Reset values
// ****************************************
`define PLLS_RST_RATIO      16'h0001
`define PLLS_RST_PHASE      16'h0000
`define PLLS_RST_DUTY       16'h0032
`define PLLS_RST_MODE       16'h0004

// ****************************************
// Ranges and loop constants
// ****************************************
`define PLLS_TAP_PAD        3'h0
`define PLLS_DEG_FULL       9'h168
`define PLLS_PCT_MIN        7'h01
`define PLLS_PCT_MAX        7'h63
`define PLLS_PCT_FULL       7'h64
`define PLLS_RATIO_MAX      8'h80
`define PLLS_MULT_MAX       8'h40
`define PLLS_PRESCALE_MAX   8'h34
`define PLLS_LOCK_WIN       24'h000004
`define PLLS_FREQ_TOL       16'h0001
`define PLLS_LOCK_HIGH      8'h04
`define PLLS_LOCK_LOW       8'h10
`define PLLS_LOCK_OPT       8'h08
`define PLLS_ST_LOCK_BIT    0
`define PLLS_ST_SEL_BIT     1
`define PLLS_ST_BUSY_BIT    2

`endif

// File: src/plls_pkg.sv
// Types shared by the clock synthesizer files.
// Assumes plls_map.svh is on the include path.
`include "plls_map.svh"

package plls_pkg;
    typedef enum logic [1:0] {PLLS_BW_HIGH, PLLS_BW_LOW, PLLS_BW_OPT} plls_bw_t;
    typedef enum logic {PLLS_PORT_IDLE, PLLS_PORT_WAIT} plls_port_state_t;
endpackage

// File: src/plls_out_counter.sv
// One output counter: divides the oscillator tap stream to a clock with set phase and duty.
// Assumes tick and align come from logic on core_clk.
`timescale 1ns/1ps
`default_nettype none

module plls_out_counter (
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Oscillator tap stream
    input  wire logic        tick,
    input  wire logic        align,
    // Settings in tap units
    input  wire logic [10:0] period_ticks,
    input  wire logic [10:0] shift_ticks,
    input  wire logic [10:0] high_ticks,
    // Clock out
    output logic             clk_out
);
    logic [10:0] pos_q;
    logic [10:0] rel_w;

    always_comb
    begin
        if (pos_q >= shift_ticks)
            rel_w = pos_q - shift_ticks;
        else
            rel_w = pos_q + period_ticks - shift_ticks;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || align)
            pos_q <= '0;
        else if (tick)
            pos_q <= (pos_q >= period_ticks - 11'h001) ? 11'h000 : pos_q + 11'h001;
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n || align)
            clk_out <= 1'b0;
        else if (tick)
            clk_out <= (rel_w < high_ticks);
    end

    AST_POS_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
        tick && !align && pos_q == period_ticks - 11'h001 && $stable(period_ticks)
        |=> pos_q == 11'h000)
        else $error("counter did not wrap at its period");

    AST_OUT_PHASE: assert property (@(posedge core_clk) disable iff (!rst_n)
        tick && !align && $stable(shift_ticks) && $stable(high_ticks) && rel_w == 11'h000
        |=> clk_out)
        else $error("output not high at its phase point");
endmodule

`default_nettype wire

// File: src/plls_synth.sv
// Clock synthesizer: reference mux, shared tap oscillator, six output counters, feedback
// counter, lock detection and a reconfiguration port on its own clock.
// Assumes core_clk is much faster than the reference clocks; refs and pins are asynchronous.
//
// Behaviour
// - Select high passes primary reference, low passes secondary, switchable any time.
// - synth_reset sets its bridge at once; loop registers clear on the next core_clk edge, core_cfg_q is kept; synthesizer restarts by itself on release.
// - Write strobe with enable stores write data at the addressed location.
// - Enable starts each access; while it is low, read bus shows status.
// - Each enable is answered by a ready pulse marking completion and read data.
// - All port signals are sampled and driven on the port clock.
// - Six output clocks, each own counter, ratio 1 to 128.
// - Feedback clock output from its own counter dividing the oscillator.
// - Reference and generated clocks are phase aligned once settled.
// - Companion outputs share the counters of the matching general outputs.
// - Lock is synchronous, set only with phase window and frequency match.
// - Output frequency is input times multiplier over prescale and ratio.
// - Phase setting 0 to 360 degrees, default 0, sets output delay.
// - Duty setting 0.01 to 0.99, default 0.50.
// - Feedback multiplier 1 to 64, default 1, scales the six output and companion clocks, not the feedback clock.
// - Prescale 1 to 52, default 1, divides reference before the loop.
// - Compensation selects system-synchronous (default) or source-synchronous feedback.
// - Bandwidth selects high, low or optimized, optimized default.
// - All counters run from one common oscillator.
// - Oscillator offers eight taps, 45 degrees apart, for phase resolution.
`timescale 1ns/1ps
`default_nettype none
`include "plls_map.svh"

module plls_synth (
    // Core clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // Reference inputs
    input  wire logic        primary_ref_clk,
    input  wire logic        secondary_ref_clk,
    input  wire logic        ref_select,
    input  wire logic        feedback_clk_in,
    input  wire logic        synth_reset,
    // Reconfiguration port
    input  wire logic        reconfig_port_clk,
    input  wire logic [4:0]  reconfig_addr,
    input  wire logic [15:0] reconfig_write_bus,
    input  wire logic        reconfig_write_strobe,
    input  wire logic        reconfig_port_enable,
    output logic [15:0]      reconfig_read_bus,
    output logic             reconfig_ready,
    // Clock outputs
    output logic [5:0]       synth_clk_out,
    output logic [5:0]       companion_clk_out,
    output logic             feedback_clk_out,
    output logic             companion_feedback_out,
    output logic             synth_locked
);
    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [15:0] cfg_default(input int idx);
        if (idx < int'(`PLLS_ADDR_PHASE0))
            return `PLLS_RST_RATIO;
        else if (idx < int'(`PLLS_ADDR_DUTY0))
            return `PLLS_RST_PHASE;
        else if (idx < int'(`PLLS_ADDR_FBMULT))
            return `PLLS_RST_DUTY;
        else if (idx == int'(`PLLS_ADDR_MODE))
            return `PLLS_RST_MODE;
        else if (idx == int'(`PLLS_ADDR_FBPHASE))
            return `PLLS_RST_PHASE;
        return `PLLS_RST_RATIO;
    endfunction

    function automatic logic [7:0] clamp_ratio(input logic [15:0] v, input logic [7:0] maxv);
        if (v == 16'h0000)
            return 8'h01;
        if (v > {8'h00, maxv})
            return maxv;
        return v[7:0];
    endfunction

    function automatic logic [10:0] phase_ticks(input logic [10:0] per, input logic [15:0] deg);
        logic [19:0] prod;
        logic [8:0]  d;
        d = (deg > {7'h00, `PLLS_DEG_FULL}) ? `PLLS_DEG_FULL : deg[8:0];
        prod = (20'(per) * 20'(d)) / 20'(`PLLS_DEG_FULL);
        return (prod >= 20'(per)) ? 11'h000 : prod[10:0];
    endfunction

    function automatic logic [10:0] high_ticks(input logic [10:0] per, input logic [15:0] pct);
        logic [17:0] prod;
        logic [6:0]  p;
        p = (pct < 16'(`PLLS_PCT_MIN)) ? `PLLS_PCT_MIN :
            (pct > 16'(`PLLS_PCT_MAX)) ? `PLLS_PCT_MAX : pct[6:0];
        prod = (18'(per) * 18'(p)) / 18'(`PLLS_PCT_FULL);
        if (prod == 18'h00000)
            return 11'h001;
        return (prod >= 18'(per)) ? per - 11'h001 : prod[10:0];
    endfunction

    // ****************************************
    // Reset bridge and pin synchronisers
    // ****************************************
    logic srst_meta_q, srst_sync_q, core_rst_n;
    logic ref1_s1_q, ref1_s2_q, ref2_s1_q, ref2_s2_q, sel_s1_q, sel_s2_q;
    logic fbin_s1_q, fbin_s2_q, ref_last_q, fbin_last_q, fbint_last_q;
    logic ref_mux_w, ref_edge_w, fb_edge_w, fb_src_w;

    always_ff @(posedge core_clk or posedge synth_reset)
    begin
        if (synth_reset)
        begin
            srst_meta_q <= 1'b1;
            srst_sync_q <= 1'b1;
        end
        else
        begin
            srst_meta_q <= 1'b0;
            srst_sync_q <= srst_meta_q;
        end
    end
    assign core_rst_n = rst_n && !srst_sync_q;

    always_ff @(posedge core_clk)
    begin
        ref1_s1_q <= primary_ref_clk;
        ref1_s2_q <= ref1_s1_q;
        ref2_s1_q <= secondary_ref_clk;
        ref2_s2_q <= ref2_s1_q;
        sel_s1_q  <= ref_select;
        sel_s2_q  <= sel_s1_q;
        fbin_s1_q <= feedback_clk_in;
        fbin_s2_q <= fbin_s1_q;
    end

    assign ref_mux_w = sel_s2_q ? ref1_s2_q : ref2_s2_q;

    // ****************************************
    // Configuration in the core domain
    // ****************************************
    logic [15:0] port_cfg_q [`PLLS_NUM_CFG];
    logic [15:0] core_cfg_q [`PLLS_NUM_CFG];
    logic        req_q, ack_q, req_s1_q, req_s2_q, cfg_upd_w;
    logic [7:0]  mult_w, pre_w, lock_thr_w;
    logic        src_sync_w;

    assign cfg_upd_w = req_s2_q != ack_q;

    always_ff @(posedge core_clk)
    begin
        req_s1_q <= req_q;
        req_s2_q <= req_s1_q;
        if (!rst_n)
            ack_q <= 1'b0;
        else if (cfg_upd_w)
            ack_q <= req_s2_q;
    end

    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < `PLLS_NUM_CFG; i++)
        begin
            if (!rst_n)
                core_cfg_q[i] <= cfg_default(i);
            else if (cfg_upd_w)
                core_cfg_q[i] <= port_cfg_q[i];
        end
    end

    assign mult_w     = clamp_ratio(core_cfg_q[`PLLS_ADDR_FBMULT], `PLLS_MULT_MAX);
    assign pre_w      = clamp_ratio(core_cfg_q[`PLLS_ADDR_PRESCALE], `PLLS_PRESCALE_MAX);
    assign src_sync_w = core_cfg_q[`PLLS_ADDR_MODE][`PLLS_MODE_COMP_BIT];

    always_comb
    begin
        unique case (plls_pkg::plls_bw_t'(core_cfg_q[`PLLS_ADDR_MODE][`PLLS_MODE_BW_HI:`PLLS_MODE_BW_LO]))
            plls_pkg::PLLS_BW_HIGH: lock_thr_w = `PLLS_LOCK_HIGH;
            plls_pkg::PLLS_BW_LOW:  lock_thr_w = `PLLS_LOCK_LOW;
            default:                lock_thr_w = `PLLS_LOCK_OPT;
        endcase
    end

    // ****************************************
    // Reference measurement and shared oscillator
    // ****************************************
    logic [15:0] per_cnt_q, per_q;
    logic [7:0]  pre_cnt_q;
    logic [23:0] acc_q, inc_w, limit_w, sum_w, pfd_age_q, fb_err_w;
    logic        pfd_evt_w, tick_w, align_w, per_valid_q, freq_ok_q, phase_ok_q, locked_q;
    logic [7:0]  lock_cnt_q;

    assign ref_edge_w = ref_mux_w && !ref_last_q;
    assign pfd_evt_w  = ref_edge_w && (pre_cnt_q >= pre_w - 8'h01);
    assign inc_w      = 24'({mult_w, `PLLS_TAP_PAD});
    assign limit_w    = 24'(pre_w) * 24'(per_q);
    assign sum_w      = acc_q + inc_w;
    assign tick_w     = per_valid_q && (sum_w >= limit_w);
    assign align_w    = cfg_upd_w || (pfd_evt_w && !locked_q);

    always_ff @(posedge core_clk)
    begin
        if (!core_rst_n)
        begin
            ref_last_q  <= 1'b0;
            per_cnt_q   <= 16'h0000;
            per_q       <= 16'h0000;
            per_valid_q <= 1'b0;
            freq_ok_q   <= 1'b0;
        end
        else
        begin
            ref_last_q <= ref_mux_w;
            if (ref_edge_w)
            begin
                per_cnt_q   <= 16'h0001;
                per_q       <= per_cnt_q;
                per_valid_q <= per_cnt_q != 16'h0000;
                freq_ok_q   <= (per_cnt_q >= per_q ? per_cnt_q - per_q : per_q - per_cnt_q)
                               <= `PLLS_FREQ_TOL;
            end
            else if (per_cnt_q != 16'hffff)
                per_cnt_q <= per_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!core_rst_n)
            pre_cnt_q <= 8'h00;
        else if (ref_edge_w)
            pre_cnt_q <= pfd_evt_w ? 8'h00 : pre_cnt_q + 8'h01;
    end

    always_ff @(posedge core_clk)
    begin
        if (!core_rst_n || align_w)
            acc_q <= 24'h000000;
        else if (tick_w)
            acc_q <= (sum_w - limit_w >= limit_w) ? 24'h000000 : sum_w - limit_w;
        else
            acc_q <= sum_w;
    end

    // ****************************************
    // Output and feedback counters
    // ****************************************
    logic [10:0] per_t_w [`PLLS_NUM_OUT];
    logic [10:0] fb_per_w;
    logic        fb_int_w;

    for (genvar g = 0; g < `PLLS_NUM_OUT; g++)
    begin : g_out
        assign per_t_w[g] = {clamp_ratio(core_cfg_q[int'(`PLLS_ADDR_RATIO0) + g], `PLLS_RATIO_MAX),
                             `PLLS_TAP_PAD};
        plls_out_counter u_cnt (
            .core_clk     (core_clk),
            .rst_n        (core_rst_n),
            .tick         (tick_w),
            .align        (align_w),
            .period_ticks (per_t_w[g]),
            .shift_ticks  (phase_ticks(per_t_w[g], core_cfg_q[int'(`PLLS_ADDR_PHASE0) + g])),
            .high_ticks   (high_ticks(per_t_w[g], core_cfg_q[int'(`PLLS_ADDR_DUTY0) + g])),
            .clk_out      (synth_clk_out[g])
        );
    end

    assign fb_per_w = {mult_w, `PLLS_TAP_PAD};
    plls_out_counter u_fb_cnt (
        .core_clk     (core_clk),
        .rst_n        (core_rst_n),
        .tick         (tick_w),
        .align        (align_w),
        .period_ticks (fb_per_w),
        .shift_ticks  (phase_ticks(fb_per_w, core_cfg_q[`PLLS_ADDR_FBPHASE])),
        .high_ticks   (high_ticks(fb_per_w, `PLLS_RST_DUTY)),
        .clk_out      (fb_int_w)
    );

    assign companion_clk_out      = synth_clk_out;
    assign feedback_clk_out       = fb_int_w;
    assign companion_feedback_out = fb_int_w;

    // ****************************************
    // Phase check and lock
    // ****************************************
    assign fb_src_w  = src_sync_w ? fb_int_w : fbin_s2_q;
    assign fb_edge_w = src_sync_w ? (fb_int_w && !fbint_last_q) : (fb_src_w && !fbin_last_q);
    assign fb_err_w  = (pfd_age_q + pfd_age_q > limit_w) ? limit_w - pfd_age_q : pfd_age_q;

    always_ff @(posedge core_clk)
    begin
        if (!core_rst_n)
        begin
            fbin_last_q  <= 1'b0;
            fbint_last_q <= 1'b0;
            pfd_age_q    <= 24'h000000;
            phase_ok_q   <= 1'b0;
        end
        else
        begin
            fbin_last_q  <= fbin_s2_q;
            fbint_last_q <= fb_int_w;
            pfd_age_q    <= pfd_evt_w ? 24'h000000 : pfd_age_q + 24'h000001;
            if (fb_edge_w)
                phase_ok_q <= fb_err_w <= `PLLS_LOCK_WIN;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!core_rst_n || cfg_upd_w)
        begin
            lock_cnt_q <= 8'h00;
            locked_q   <= 1'b0;
        end
        else if (pfd_evt_w)
        begin
            if (phase_ok_q && freq_ok_q && per_valid_q)
            begin
                lock_cnt_q <= (lock_cnt_q < lock_thr_w) ? lock_cnt_q + 8'h01 : lock_cnt_q;
                locked_q   <= lock_cnt_q >= lock_thr_w;
            end
            else
            begin
                lock_cnt_q <= 8'h00;
                locked_q   <= 1'b0;
            end
        end
    end
    assign synth_locked = locked_q;

    // ****************************************
    // Reconfiguration port (port clock)
    // ****************************************
    logic prst_s1_q, prst_s2_q, ack_s1_q, ack_s2_q, lock_s1_q, lock_s2_q, psel_s1_q, psel_s2_q;
    logic [15:0] status_w;
    plls_pkg::plls_port_state_t pstate_q;

    always_ff @(posedge reconfig_port_clk)
    begin
        prst_s1_q <= rst_n;
        prst_s2_q <= prst_s1_q;
        ack_s1_q  <= ack_q;
        ack_s2_q  <= ack_s1_q;
        lock_s1_q <= locked_q;
        lock_s2_q <= lock_s1_q;
        psel_s1_q <= ref_select;
        psel_s2_q <= psel_s1_q;
    end

    always_comb
    begin
        status_w = 16'h0000;
        status_w[`PLLS_ST_LOCK_BIT] = lock_s2_q;
        status_w[`PLLS_ST_SEL_BIT]  = psel_s2_q;
        status_w[`PLLS_ST_BUSY_BIT] = pstate_q == plls_pkg::PLLS_PORT_WAIT;
    end

    always_ff @(posedge reconfig_port_clk)
    begin
        for (int i = 0; i < `PLLS_NUM_CFG; i++)
        begin
            if (!prst_s2_q)
                port_cfg_q[i] <= cfg_default(i);
            else if (pstate_q == plls_pkg::PLLS_PORT_IDLE && reconfig_port_enable &&
                     reconfig_write_strobe && int'(reconfig_addr) == i)
                port_cfg_q[i] <= reconfig_write_bus;
        end
    end

    always_ff @(posedge reconfig_port_clk)
    begin
        if (!prst_s2_q)
        begin
            pstate_q          <= plls_pkg::PLLS_PORT_IDLE;
            req_q             <= 1'b0;
            reconfig_ready    <= 1'b0;
            reconfig_read_bus <= 16'h0000;
        end
        else
        begin
            reconfig_ready <= 1'b0;
            unique case (pstate_q)
                plls_pkg::PLLS_PORT_IDLE:
                begin
                    if (reconfig_port_enable && reconfig_write_strobe)
                    begin
                        req_q    <= !req_q;
                        pstate_q <= plls_pkg::PLLS_PORT_WAIT;
                    end
                    else if (reconfig_port_enable)
                    begin
                        reconfig_ready    <= 1'b1;
                        reconfig_read_bus <= (int'(reconfig_addr) < `PLLS_NUM_CFG) ?
                                             port_cfg_q[reconfig_addr] : 16'h0000;
                    end
                    else
                        reconfig_read_bus <= status_w;
                end
                plls_pkg::PLLS_PORT_WAIT:
                begin
                    if (!reconfig_port_enable)
                        reconfig_read_bus <= status_w;
                    if (ack_s2_q == req_q)
                    begin
                        reconfig_ready <= 1'b1;
                        pstate_q       <= plls_pkg::PLLS_PORT_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    AST_READ_READY: assert property (@(posedge reconfig_port_clk) disable iff (!prst_s2_q)
        pstate_q == plls_pkg::PLLS_PORT_IDLE && reconfig_port_enable && !reconfig_write_strobe
        |=> reconfig_ready &&
            (reconfig_read_bus == $past(port_cfg_q[0]) || $past(reconfig_addr) != 5'h00))
        else $error("read not answered next port cycle");

    AST_WRITE_READY: assert property (@(posedge reconfig_port_clk) disable iff (!prst_s2_q)
        pstate_q == plls_pkg::PLLS_PORT_IDLE && reconfig_port_enable && reconfig_write_strobe
        |=> !reconfig_ready ##[1:40] reconfig_ready)
        else $error("write not answered in time");

    AST_READY_PULSE: assert property (@(posedge reconfig_port_clk) disable iff (!prst_s2_q)
        reconfig_ready |=> !reconfig_ready)
        else $error("ready longer than one port cycle");

    AST_STATUS_IDLE: assert property (@(posedge reconfig_port_clk) disable iff (!prst_s2_q)
        !reconfig_port_enable && pstate_q == plls_pkg::PLLS_PORT_IDLE
        |=> reconfig_read_bus[`PLLS_ST_LOCK_BIT] == $past(lock_s2_q))
        else $error("read bus not showing status while idle");

    AST_LOCK_DROP: assert property (@(posedge core_clk) disable iff (!rst_n)
        pfd_evt_w && !(phase_ok_q && freq_ok_q) |=> !synth_locked)
        else $error("lock held after failed check");

    AST_RESET_UNLOCK: assert property (@(posedge core_clk)
        srst_sync_q |=> !synth_locked && synth_clk_out == 6'h00)
        else $error("outputs active during reset");

    COV_LOCK: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(synth_locked));
    COV_WRITE: cover property (@(posedge reconfig_port_clk) disable iff (!prst_s2_q)
        pstate_q == plls_pkg::PLLS_PORT_WAIT ##1 reconfig_ready);
    COV_SWITCH: cover property (@(posedge core_clk) disable iff (!rst_n)
        $fell(sel_s2_q) && synth_locked);
endmodule

`default_nettype wire

// File: verification/plls_ref_model.sv
// Reference clock sources and feedback loop around the synthesizer.
// Assumes the bench connects the feedback output back through this model.
`timescale 1ns/1ps
`default_nettype none

module plls_ref_model (
    // Reference clocks
    output logic      primary_ref_clk,
    output logic      secondary_ref_clk,
    // Feedback path
    input  wire logic feedback_clk_out,
    output logic      feedback_clk_in
);
    initial
    begin
        primary_ref_clk = 1'b0;
        forever #200 primary_ref_clk = ~primary_ref_clk;
    end
    // Same rate as primary, shifted just past a quarter period to miss core edges
    initial
    begin
        secondary_ref_clk = 1'b0;
        #110;
        forever #200 secondary_ref_clk = ~secondary_ref_clk;
    end
    assign feedback_clk_in = feedback_clk_out;
endmodule

`default_nettype wire

// File: verification/plls_synth_tb.sv
// Self-checking bench of the clock synthesizer through its reconfiguration port.
// Assumes plls_ref_model supplies the references and the feedback loop.
`timescale 1ns/1ps
`default_nettype none

module plls_synth_tb;
    logic        core_clk, rst_n, reconfig_port_clk, ref_select, synth_reset;
    logic        primary_ref_clk, secondary_ref_clk, feedback_clk_in, reconfig_ready;
    logic [4:0]  reconfig_addr;
    logic [15:0] reconfig_write_bus, reconfig_read_bus, rd;
    logic        reconfig_write_strobe, reconfig_port_enable, synth_locked;
    logic [5:0]  synth_clk_out, companion_clk_out;
    logic        feedback_clk_out, companion_feedback_out;
    int          bad_count, total_checks, n0, n1, nf, nc;

    plls_synth i_plls_synth (.core_clk, .rst_n, .primary_ref_clk, .secondary_ref_clk,
        .ref_select, .feedback_clk_in, .synth_reset, .reconfig_port_clk, .reconfig_addr,
        .reconfig_write_bus, .reconfig_write_strobe, .reconfig_port_enable,
        .reconfig_read_bus, .reconfig_ready, .synth_clk_out, .companion_clk_out,
        .feedback_clk_out, .companion_feedback_out, .synth_locked);
    plls_ref_model i_plls_ref_model (.primary_ref_clk, .secondary_ref_clk,
        .feedback_clk_out, .feedback_clk_in);

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial
    begin
        reconfig_port_clk = 1'b0;
        #7;
        forever #16 reconfig_port_clk = ~reconfig_port_clk;
    end
    initial
    begin
        #3000000;
        bad_count++;
        complete_run();
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // One access; idle bus values stay zero between accesses
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d);
        @(posedge reconfig_port_clk) #1;
        {reconfig_port_enable, reconfig_write_strobe, reconfig_addr, reconfig_write_bus} = {1'b1, w, a, d};
        @(posedge reconfig_port_clk) #1;
        {reconfig_port_enable, reconfig_write_strobe, reconfig_addr, reconfig_write_bus} =
            23'h0;
        for (int i = 0; i < 60 && reconfig_ready !== 1'b1; i++) @(posedge reconfig_port_clk) #1;
        chk("ready", 16'h1, {15'h0, reconfig_ready});
        rd = reconfig_read_bus;
        @(posedge reconfig_port_clk) #1;
        chk("ready pulse", 16'h0, {15'h0, reconfig_ready});
    endtask
    task automatic wlock();
        for (int i = 0; i < 4000 && synth_locked !== 1'b1; i++) @(posedge core_clk) #1;
    endtask
    task automatic meas();
        logic [5:0] p;
        logic       pf;
        {n0, n1, nf, nc} = '0;
        p = synth_clk_out;
        pf = feedback_clk_out;
        repeat (800)
        begin
            @(posedge core_clk) #1;
            n0 += int'(synth_clk_out[0] & ~p[0]);
            n1 += int'(synth_clk_out[1] & ~p[1]);
            nf += int'(feedback_clk_out & ~pf);
            nc += int'({companion_clk_out, companion_feedback_out} !== {synth_clk_out, feedback_clk_out});
            p = synth_clk_out;
            pf = feedback_clk_out;
        end
    endtask
    function automatic logic [15:0] dflt(input int a);
        if (a < 6 || a == 18 || a == 19) return 16'h0001;
        if (a >= 12 && a < 18) return 16'h0032;
        return (a == 21) ? 16'h0004 : 16'h0000;
    endfunction
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ****************************************
    // Test sequence
    // ****************************************
    initial
    begin
        {rst_n, synth_reset, ref_select} = 3'b001;
        {reconfig_port_enable, reconfig_write_strobe, reconfig_addr, reconfig_write_bus} = 23'h0;
        repeat (2) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge reconfig_port_clk);
        #1 chk("status", 16'h0002, reconfig_read_bus);
        for (int a = 0; a < 32; a++)
        begin
            acc(1'b0, 5'(a), 16'h0);
            chk("default", dflt(a), rd);
        end
        $display("test defaults finished");
        acc(1'b1, 5'h01, 16'h00c8);
        acc(1'b0, 5'h01, 16'h0);
        chk("ratio stored", 16'h00c8, rd);
        acc(1'b1, 5'h01, 16'h0002);
        acc(1'b0, 5'h01, 16'h0);
        chk("ratio", 16'h0002, rd);
        wlock();
        chk("locked", 16'h1, {15'h0, synth_locked});
        meas();
        chk("out0 edges", 16'h1, {15'h0, n0 inside {[79:81]}});
        chk("out1 edges", 16'h1, {15'h0, n1 inside {[39:41]}});
        chk("fb edges", 16'h1, {15'h0, nf inside {[79:81]}});
        chk("companion", 16'h0, 16'(nc));
        acc(1'b1, 5'h12, 16'h0002);
        chk("lock drop", 16'h0, {15'h0, synth_locked});
        acc(1'b1, 5'h13, 16'h0004);
        wlock();
        meas();
        chk("out0 scaled", 16'h1, {15'h0, n0 inside {[39:41]}});
        chk("fb scaled", 16'h1, {15'h0, nf inside {[19:21]}});
        $display("test rates finished");
        for (int m = 5; m >= 0; m--)
        begin
            acc(1'b1, 5'h15, 16'(m));
            acc(1'b0, 5'h15, 16'h0);
            chk("mode", 16'(m), rd);
        end
        // Source-synchronous feedback: no pin sync delay in the phase check
        acc(1'b1, 5'h15, 16'h0005);
        wlock();
        chk("relock", 16'h1, {15'h0, synth_locked});
        @(posedge core_clk) #1 synth_reset = 1'b1;
        repeat (4) @(posedge core_clk) #1;
        chk("reset lock", 16'h0, {15'h0, synth_locked});
        synth_reset = 1'b0;
        acc(1'b0, 5'h01, 16'h0);
        chk("config kept", 16'h0002, rd);
        wlock();
        chk("restart", 16'h1, {15'h0, synth_locked});
        $display("test synth reset finished");
        @(posedge reconfig_port_clk) #1 ref_select = 1'b0;
        repeat (6) @(posedge reconfig_port_clk) #1;
        chk("select status", 16'h0, {15'h0, reconfig_read_bus[1]});
        wlock();
        meas();
        chk("secondary rate", 16'h1, {15'h0, n0 inside {[39:41]}});
        @(posedge core_clk) #1 rst_n = 1'b0;
        repeat (3) @(posedge core_clk) #1;
        chk("rst outs", 16'h0, {9'h0, synth_clk_out, synth_locked});
        rst_n = 1'b1;
        repeat (4) @(posedge reconfig_port_clk);
        acc(1'b0, 5'h01, 16'h0);
        chk("rst ratio", 16'h0001, rd);
        $display("test select and reset finished");
        complete_run();
    end
endmodule

`default_nettype wire
